/* File: src/serial_id_device.sv */
`timescale 1ns/1ps
module serial_id_device #(
  parameter logic [127:0] SERIAL_VALUE = uid_pkg::SERIAL_DEFAULT
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // chip-select straps
  input wire logic chip_select_strap_0_i,
  input wire logic chip_select_strap_1_i,
  input wire logic chip_select_strap_2_i,
  // status
  output logic busy_o,
  // two-wire bus
  uid_bus_if.dev bus
);
  import uid_pkg::*;

  typedef struct packed {
    dev_state_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ack_ph;
    logic sda_oe;
    logic rd;
    logic id_sel;
    logic [1:0] region;
    logic [3:0] offset;
    logic [2:0] strap_m;
    logic [2:0] strap;
    logic [2:0] scl_p;
    logic [2:0] sda_p;
    logic busy;
  } dev_s;

  dev_s r;
  dev_s n;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic sda_now;
  logic uid_hit;
  logic [7:0] byte_out;

  // the serial value is a constant, so no path can alter it
  function automatic logic [7:0] fetch(input logic uid,
                                       input logic [3:0] off);
    logic [3:0] idx;
    idx = 4'(4'hf - off);
    if (uid) begin
      fetch = SERIAL_VALUE[{idx, 3'b000} +: 8]; // see R05
    end else begin
      fetch = ERASED_BYTE; // see R10 see R11
    end
  endfunction

  // only the second and third sync stages feed the edge logic
  assign sda_now = r.sda_p[1];
  assign rise = r.scl_p[1] & !r.scl_p[2];
  assign fall = !r.scl_p[1] & r.scl_p[2];
  assign start = r.scl_p[1] & r.scl_p[2] & r.sda_p[2] & !r.sda_p[1];
  assign stop = r.scl_p[1] & r.scl_p[2] & !r.sda_p[2] & r.sda_p[1];
  assign uid_hit = r.id_sel && (r.region == REGION_SERIAL); // see R01 see R02
  assign byte_out = fetch(uid_hit, r.offset);

  always_comb begin
    n = r;
    n.scl_p = {r.scl_p[1:0], bus.scl};
    n.sda_p = {r.sda_p[1:0], bus.sda};
    n.strap_m = {chip_select_strap_2_i, chip_select_strap_1_i,
                 chip_select_strap_0_i};
    n.strap = r.strap_m;
    if (start) begin
      n.st = ST_DEV;
      n.cnt = 4'h0;
      n.ack_ph = 1'b0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.st = ST_IDLE; // see R09
      n.sda_oe = 1'b0;
      n.ack_ph = 1'b0;
    end else if (rise) begin
      case (r.st)
        ST_DEV, ST_AHI, ST_ALO, ST_WDAT: begin
          if (!r.ack_ph) begin
            n.sh = {r.sh[6:0], sda_now};
            n.cnt = 4'(r.cnt + 4'h1);
          end
        end
        ST_TXACK: begin
          if (sda_now) begin
            // master refused the byte: stay off the wire until stop
            n.st = ST_WAIT; // see R09
          end else begin
            // four-bit offset rolls from 15 back to 0 by itself
            n.offset = 4'(r.offset + 4'h1); // see R07 see R08 see R14
            n.st = ST_TX;
            n.cnt = 4'h0;
          end
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      case (r.st)
        ST_DEV, ST_AHI, ST_ALO, ST_WDAT: begin
          if (r.ack_ph) begin
            n.ack_ph = 1'b0;
            n.sda_oe = 1'b0;
            n.cnt = 4'h0;
            case (r.st)
              ST_DEV: begin
                if (r.rd) begin
                  n.st = ST_TX; // see R12
                  n.sda_oe = !byte_out[7];
                  n.sh = {byte_out[6:0], 1'b0};
                  n.cnt = 4'h1;
                end else begin
                  n.st = ST_AHI;
                end
              end
              ST_AHI: n.st = ST_ALO;
              default: n.st = ST_WDAT;
            endcase
          end else if (r.cnt == BITS_PER_BYTE) begin
            n.sda_oe = 1'b1;
            n.ack_ph = 1'b1;
            case (r.st)
              ST_DEV: begin
                if ((r.sh[7:4] == SEL_MAIN || r.sh[7:4] == SEL_ID) &&
                    r.sh[3:1] == r.strap) begin // see R13
                  n.rd = r.sh[0];
                  n.id_sel = (r.sh[7:4] == SEL_ID); // see R01
                end else begin
                  n.st = ST_WAIT;
                  n.sda_oe = 1'b0;
                  n.ack_ph = 1'b0;
                end
              end
              ST_AHI: begin
                // upper address bits outside the region field are unused
                n.region = r.sh[REGION_LSB +: 2]; // see R02
              end
              ST_ALO: begin
                n.offset = r.sh[3:0]; // see R03
              end
              default: begin
                if (uid_hit) begin
                  // refuse data aimed at the serial block
                  n.st = ST_WAIT; // see R06
                  n.sda_oe = 1'b0;
                  n.ack_ph = 1'b0;
                end
              end
            endcase
          end
        end
        ST_TX: begin
          if (r.cnt == BITS_PER_BYTE) begin
            n.sda_oe = 1'b0;
            n.st = ST_TXACK;
          end else if (r.cnt == 4'h0) begin
            n.sda_oe = !byte_out[7]; // see R08
            n.sh = {byte_out[6:0], 1'b0};
            n.cnt = 4'h1;
          end else begin
            n.sda_oe = !r.sh[7];
            n.sh = {r.sh[6:0], 1'b0};
            n.cnt = 4'(r.cnt + 4'h1);
          end
        end
        ST_TXACK, ST_WAIT, ST_IDLE: begin
          n.sda_oe = 1'b0;
        end
        default: begin
        end
      endcase
    end
    n.busy = (n.st != ST_IDLE);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
      // idle level, so no false clock edge follows reset
      r.scl_p <= SYNC_IDLE;
      r.sda_p <= SYNC_IDLE;
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign bus.dev_sda_oe = r.sda_oe;
  assign busy_o = r.busy;
endmodule

/* File: src/serial_id_host.sv */
`timescale 1ns/1ps
module serial_id_host (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // request
  input wire logic req_i,
  input wire logic [2:0] strap_sel_i,
  output logic busy_o,
  output logic done_o,
  output logic nack_err_o,
  // serial bytes
  output logic [uid_pkg::FIFO_WIDTH-1:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  // two-wire bus
  uid_bus_if.host bus
);
  import uid_pkg::*;

  typedef struct packed {
    host_state_e st;
    logic [1:0] q;
    logic [6:0] div;
    logic [3:0] bitn;
    logic [2:0] step;
    logic [4:0] left;
    logic [7:0] sh;
    logic [2:0] sel;
    logic scl_oe;
    logic sda_oe;
    logic [1:0] sda_p;
    logic busy;
    logic done;
    logic err;
  } host_s;

  host_s r;
  host_s n;
  logic tick;
  logic rx;
  logic sda_now;
  logic push;
  logic fifo_ready;
  logic stall;

  assign tick = (r.div == QTR_LAST);
  assign rx = (r.step == 3'h5);
  assign sda_now = r.sda_p[1];
  assign stall = rx && r.bitn == 4'h0 && r.q == 2'h0 && !fifo_ready;
  assign push = tick && r.st == H_BIT && rx && r.q == 2'h2 &&
                r.bitn == 4'h7;

  always_comb begin
    n = r;
    n.sda_p = {r.sda_p[0], bus.sda};
    if (r.st != H_IDLE) begin
      n.div = tick ? 7'h00 : 7'(r.div + 7'h01);
    end
    case (r.st)
      H_IDLE: begin
        if (req_i) begin
          n.st = H_START;
          n.step = 3'h0;
          n.q = 2'h0;
          n.div = 7'h00;
          n.left = READ_BYTES; // see R04
          n.sel = strap_sel_i;
          n.busy = 1'b1;
          n.done = 1'b0;
          n.err = 1'b0;
        end
      end
      H_START: begin
        if (tick) begin
          n.q = 2'(r.q + 2'h1);
          case (r.q)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b1;
            default: begin
              n.scl_oe = 1'b1;
              n.st = H_BIT;
              n.bitn = 4'h0;
              n.sh = {SEL_ID, r.sel, r.step != 3'h0}; // see R01 see R12
              n.step = (r.step == 3'h0) ? 3'h0 : 3'h4;
            end
          endcase
        end
      end
      H_BIT: begin
        // a full fifo holds the clock low before a new byte
        if (tick && !stall) begin
          n.q = 2'(r.q + 2'h1);
          case (r.q)
            2'h0: begin
              if (r.bitn == BITS_PER_BYTE) begin
                n.sda_oe = rx && (r.left != 5'h01); // see R09
              end else begin
                n.sda_oe = !rx && !r.sh[7];
              end
            end
            2'h1: n.scl_oe = 1'b0;
            2'h2: begin
              if (r.bitn != BITS_PER_BYTE) begin
                n.sh = {r.sh[6:0], sda_now};
              end else if (!rx && sda_now) begin
                n.err = 1'b1;
              end
            end
            default: begin
              n.scl_oe = 1'b1;
              n.bitn = 4'(r.bitn + 4'h1);
              if (r.bitn == BITS_PER_BYTE) begin
                n.bitn = 4'h0;
                if (r.err) begin
                  n.st = H_STOP;
                end else if (rx) begin
                  n.left = 5'(r.left - 5'h01);
                  n.st = (r.left == 5'h01) ? H_STOP : H_BIT;
                end else begin
                  n.step = 3'(r.step + 3'h1);
                  n.sh = (r.step == 3'h0) ? ADDR_HI_SERIAL
                                          : ADDR_LO_FIRST; // see R05
                  n.st = (r.step == 3'h2) ? H_START : H_BIT;
                end
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          n.q = 2'(r.q + 2'h1);
          case (r.q)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b0;
            default: begin
              n.st = H_IDLE;
              n.busy = 1'b0;
              n.done = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= n;
    end
  end

  uid_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .in_valid_i(push),
    .in_data_i({r.sh[6:0], sda_now}),
    .in_ready_o(fifo_ready),
    .out_valid_o(rd_valid_o),
    .out_data_o(rd_data_o),
    .out_ready_i(rd_ready_i)
  );

  assign bus.host_scl_oe = r.scl_oe;
  assign bus.host_sda_oe = r.sda_oe;
  assign busy_o = r.busy;
  assign done_o = r.done;
  assign nack_err_o = r.err;
endmodule

/* File: src/uid_bus_if.sv */
`timescale 1ns/1ps
interface uid_bus_if;
  // enables are high while that end pulls the wire low
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  assign scl = !host_scl_oe;
  assign sda = !(host_sda_oe | dev_sda_oe);

  modport host (
    output host_scl_oe,
    output host_sda_oe,
    input scl,
    input sda
  );

  modport dev (
    output dev_sda_oe,
    input scl,
    input sda
  );
endinterface

/* File: src/uid_fifo.sv */
`timescale 1ns/1ps
module uid_fifo #(
  parameter int WIDTH = uid_pkg::FIFO_WIDTH,
  parameter int DEPTH = uid_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  import uid_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic nonempty;
  } fifo_s;

  fifo_s r;
  fifo_s n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (r.wp == r.rp);
  assign full = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;

  always_comb begin
    n = r;
    if (push) begin
      n.wp = (AW + 1)'(r.wp + 1'b1);
    end
    if (pop) begin
      n.rp = (AW + 1)'(r.rp + 1'b1);
    end
    // registered so the drain side sees a flop, not pointer compare logic
    n.nonempty = (n.wp != n.rp);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem[r.wp[AW-1:0]] <= in_data_i;
    end
  end

  assign in_ready_o = !full;
  assign out_valid_o = r.nonempty;
  assign out_data_o = mem[r.rp[AW-1:0]];
endmodule

/* File: src/uid_pkg.sv */
// Behaviour
// R01: serial block answers only the 1011 type selector
// R02: region bits 10:9 equal 01; others ignored
// R03: address bits 3:0 load the byte offset
// R04: master reads all 16 bytes from offset zero; the host reads READ_BYTES = 17 bytes, one past the block
// R05: offset 0000 selects the first serial byte
// R06: serial number contents can never change
// R07: after byte 15 the offset wraps to 0
// R08: offset advances after every byte sent; the device advances it only when the master acks the byte
// R09: nack then stop ends read; device releases data
// R10: main array reads all ones when erased
// R11: identification page reads all ones when erased
// R12: dummy write, repeated start, then read address
// R13: acknowledge only when strap bits match
// R14: each master ack fetches the next byte
package uid_pkg;

  localparam logic [3:0] SEL_MAIN = 4'ha;
  localparam logic [3:0] SEL_ID = 4'hb;
  localparam logic [1:0] REGION_SERIAL = 2'h1;
  localparam int REGION_LSB = 1;
  localparam logic [7:0] ADDR_HI_SERIAL = {5'h00, REGION_SERIAL, 1'b0};
  localparam logic [7:0] ADDR_LO_FIRST = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [4:0] SERIAL_BYTES = 5'h10;
  // one byte past the block, so the offset wrap shows on the bus
  localparam logic [4:0] READ_BYTES = 5'(SERIAL_BYTES + 5'h01);
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // device pin synchronisers start at the idle bus level
  localparam logic [2:0] SYNC_IDLE = 3'h7;
  // arbitrary factory value, byte 0 in the top bits
  localparam logic [127:0] SERIAL_DEFAULT =
    128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;

  localparam int CLK_PERIOD_NS = 40;
  localparam int SCL_PERIOD_NS = 10_000;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);

  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_AHI = 3'b010,
    ST_ALO = 3'b011,
    ST_WDAT = 3'b100,
    ST_TX = 3'b101,
    ST_TXACK = 3'b110,
    ST_WAIT = 3'b111
  } dev_state_e;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BIT = 2'b10,
    H_STOP = 2'b11
  } host_state_e;

endpackage

/* File: testbench/test_unique_id_read_path.sv */
`timescale 1ns/1ps
module test_unique_id_read_path;
  import uid_pkg::*;

  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req_i = 1'b0;
  logic rd_ready_i = 1'b0;
  logic [2:0] strap_sel_i = 3'h5;
  logic [2:0] strap = 3'h5;
  logic busy_o;
  logic done_o;
  logic nack_err_o;
  logic rd_valid_o;
  logic dev_busy;
  logic [7:0] rd_data_o;
  int n_fail = 0;
  int samples_checked = 0;

  uid_bus_if i_uid_bus_if ();

  serial_id_host i_serial_id_host (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .req_i(req_i), .strap_sel_i(strap_sel_i), .busy_o(busy_o),
    .done_o(done_o), .nack_err_o(nack_err_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
    .bus(i_uid_bus_if.host));

  serial_id_device i_serial_id_device (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .chip_select_strap_0_i(strap[0]), .chip_select_strap_1_i(strap[1]),
    .chip_select_strap_2_i(strap[2]), .busy_o(dev_busy),
    .bus(i_uid_bus_if.dev));

  uid_bus_asserts i_uid_bus_asserts (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .host_scl_oe(i_uid_bus_if.host_scl_oe),
    .host_sda_oe(i_uid_bus_if.host_sda_oe),
    .dev_sda_oe(i_uid_bus_if.dev_sda_oe),
    .scl(i_uid_bus_if.scl), .sda(i_uid_bus_if.sda));

  always #20 clk_i = ~clk_i;

  task stop_test;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task check(input string what, input logic [7:0] exp,
             input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // entered at a falling edge; returns once the host is idle again
  task run_read(input logic [2:0] sel, input int limit);
    int n;
    strap_sel_i = sel;
    req_i = 1'b1;
    @(negedge clk_i);
    req_i = 1'b0;
    check("host busy", 8'h01, {7'h00, busy_o});
    n = 0;
    while (busy_o !== 1'b0 && n < limit) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= limit) begin
      $display("[ERR] host busy expected 0 seen 1");
      n_fail++;
      stop_test();
    end
  endtask

  // drain side stalls for the whole read, so all bytes sit in the fifo
  task read_serial;
    int n;
    logic [7:0] want;
    run_read(3'h5, 60000);
    check("done", 8'h01, {7'h00, done_o});
    check("nack", 8'h00, {7'h00, nack_err_o});
    check("device busy", 8'h00, {7'h00, dev_busy});
    for (int b = 0; b < READ_BYTES; b++) begin
      n = 0;
      while (rd_valid_o !== 1'b1 && n < 8) begin
        @(negedge clk_i);
        n++;
      end
      check("serial valid", 8'h01, {7'h00, rd_valid_o});
      // the byte after the last one of the block is byte 0 again
      want = SERIAL_DEFAULT[127 - 8 * (b % 16) -: 8];
      check("serial byte", want, rd_data_o);
      rd_ready_i = 1'b1;
      @(negedge clk_i);
      rd_ready_i = 1'b0;
      repeat (2) @(negedge clk_i);
    end
    check("fifo empty", 8'h00, {7'h00, rd_valid_o});
  endtask

  // address bits differ from the straps: no answer, no data
  task strap_mismatch;
    run_read(3'h2, 20000);
    check("nack", 8'h01, {7'h00, nack_err_o});
    check("fifo empty", 8'h00, {7'h00, rd_valid_o});
    check("device busy", 8'h00, {7'h00, dev_busy});
  endtask

  initial begin
    repeat (8) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    read_serial();
    strap_mismatch();
    stop_test();
  end
endmodule

/* File: testbench/uid_bus_asserts.sv */
`timescale 1ns/1ps
module uid_bus_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // pull-down enables and resolved wires
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  import uid_pkg::*;

  // saturating run lengths of each clock level, so long idles stay cheap
  logic [7:0] hi_cnt_r;
  logic [7:0] lo_cnt_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hi_cnt_r <= 8'h00;
      lo_cnt_r <= 8'h00;
    end else begin
      hi_cnt_r <= !scl ? 8'h00 : hi_cnt_r + {7'h00, hi_cnt_r != 8'hff};
      lo_cnt_r <= scl ? 8'h00 : lo_cnt_r + {7'h00, lo_cnt_r != 8'hff};
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_dev_sda_timing: assert property (
    $changed(dev_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("device moved sda outside the low clock phase");
  a_sda_stable_high: assert property (
    scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe))
    else $error("sda changed by the device while clock high");
  a_start_by_host: assert property (
    $fell(sda) && scl |-> !dev_sda_oe)
    else $error("device drove a start condition");
  a_start_hold: assert property (
    $fell(sda) && scl |-> ##[56:68] $fell(scl))
    else $error("clock not pulled low one quarter after start");
  a_stop_release: assert property (
    $rose(sda) && scl |=> !dev_sda_oe [*8])
    else $error("device drove sda after stop");
  a_idle_release: assert property (
    hi_cnt_r > 8'hc8 |-> !dev_sda_oe)
    else $error("device holds sda on an idle bus");
  a_scl_high_min: assert property (
    $fell(scl) |-> hi_cnt_r >= 8'h64)
    else $error("clock high phase too short");
  a_scl_low_min: assert property (
    $rose(scl) |-> lo_cnt_r >= 8'h64)
    else $error("clock low phase too short");
  a_dev_bit_held: assert property (
    $rose(dev_sda_oe) |-> dev_sda_oe [*8])
    else $error("device bit dropped early");
endmodule
